// >>> design/itc_bus_cycle.sv
// one memory bus cycle: four clocks, stretched while memory is not ready
// assumes ready_sync is already synchronised to clock
`timescale 1ns/10ps
module itc_bus_cycle
  import itc_pkg::*;
(
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic start,
  input  wire logic write_in,
  input  wire logic ready_sync,
  output logic      bus_active,
  output logic      bus_write,
  output logic      cyc_done,
  output logic      wait_clk
);
  localparam logic [1:0] LAST_PHASE = 2'(BUS_CYCLE_CLKS - 1);

  logic       active_reg;
  logic       write_reg;
  logic [1:0] phase_reg;

  assign bus_active = active_reg | start;
  assign bus_write  = active_reg ? write_reg : write_in;
  assign cyc_done   = active_reg && phase_reg == LAST_PHASE && ready_sync;  // RULE1
  assign wait_clk   = active_reg && phase_reg == LAST_PHASE && !ready_sync; // RULE2

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
      phase_reg  <= 2'h0;
      write_reg  <= 1'b0;
    end else if (start && !active_reg) begin
      active_reg <= 1'b1;
      phase_reg  <= 2'h1;
      write_reg  <= write_in;
    end else if (cyc_done) begin
      active_reg <= 1'b0;
      phase_reg  <= 2'h0;
    end else if (active_reg && phase_reg != LAST_PHASE) begin
      phase_reg <= phase_reg + 2'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_cycle_open;
    start && !active_reg;
  endsequence

  chk_four_clk_cycle: assert property (s_cycle_open ##1 active_reg[*2] |=> // RULE1
    active_reg && phase_reg == LAST_PHASE)
    else $error("bus cycle did not reach its last phase after four clocks");
  chk_wait_stretch: assert property (wait_clk |=> active_reg && phase_reg == LAST_PHASE) // RULE2
    else $error("wait clock did not hold the bus cycle");
endmodule

// >>> design/itc_timing_core.sv
// cycle-count engine: plans an operation and runs its bus and idle clocks
// assumes mem_ready comes from a pin outside the clock domain
`timescale 1ns/10ps
module itc_timing_core
  import itc_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        req_valid,
  input  wire itc_op_t     req_op,
  input  wire itc_mode_t   req_src_mode,
  input  wire itc_mode_t   req_dst_mode,
  input  wire logic        req_long,
  input  wire logic        req_fetch,
  output logic             req_ready,
  input  wire logic        mem_ready,
  output logic             bus_active,
  output logic             bus_write,
  output logic             bus_wait,
  output logic             done,
  output logic             err,
  output logic [15:0]      total_clks,
  output logic [2:0]       read_cycles,
  output logic [1:0]       write_cycles,
  output logic [15:0]      wait_clks
);
  typedef enum logic [1:0] {ST_IDLE, ST_INTERNAL, ST_BUS} itc_state_t;

  itc_state_t state_reg;
  logic       ready_meta_reg;
  logic       ready_sync_reg;
  logic [5:0] plan_n_reg;
  logic [2:0] plan_r_reg;
  logic [1:0] plan_w_reg;
  logic [5:0] plan_idle_reg;
  logic [5:0] idle_left_reg;
  logic [2:0] reads_left_reg;
  logic [1:0] writes_left_reg;
  logic [15:0] elapsed_reg;
  logic [15:0] waits_reg;
  logic        done_reg;
  logic        err_reg;
  logic [15:0] total_reg;
  logic [15:0] wait_out_reg;
  logic        cyc_busy_reg;

  itc_cost_t  cost;
  itc_cost_t  src_c;
  itc_cost_t  dst_c;
  logic [5:0] idle_calc;
  logic       accept;
  logic       issue;
  logic       eng_done;
  logic       eng_wait;
  logic       eng_active;
  logic       finish;
  logic       has_cycles;
  logic       plan_cycles;

  // operation cost from the tables
  always_comb begin
    src_c = itc_ea_cost(req_src_mode, req_long, 1'b1);
    dst_c = itc_dst_cost(req_dst_mode);
    cost  = '{ok: 1'b0, n: 6'h00, r: 3'h0, w: 2'h0};
    case (req_op)
      ITC_OP_EA_CALC: cost = itc_ea_cost(req_src_mode, req_long, req_fetch); // RULE6 RULE7 RULE13
      ITC_OP_MOVE_BW: begin
        cost.ok = src_c.ok && dst_c.ok && !req_long;
        cost.n  = MOVE_BASE_CLKS + src_c.n + dst_c.n;                        // RULE14 RULE15
        cost.r  = 3'h1 + src_c.r + dst_c.r;                                  // RULE5
        cost.w  = dst_c.w;
      end
      ITC_OP_LOOP_CONT, ITC_OP_LOOP_TERM_CC, ITC_OP_LOOP_TERM_EX: begin
        cost.ok = (req_src_mode == ITC_EA_DREG || req_src_mode == ITC_EA_AREG) &&
                  (req_dst_mode == ITC_EA_IND || req_dst_mode == ITC_EA_POSTINC) && !req_long;
        cost.w  = 2'h1;
        if (req_op == ITC_OP_LOOP_CONT) begin
          cost.n = LOOP_CONT_CLKS;                                           // RULE16
        end else begin
          cost.n = (req_op == ITC_OP_LOOP_TERM_CC) ? LOOP_TERM_CC_CLKS : LOOP_TERM_EX_CLKS;
          cost.r = LOOP_TERM_READS;
        end
      end
      default: cost.ok = 1'b0;
    endcase
    idle_calc = cost.n - 6'(BUS_CYCLE_CLKS * (cost.r + cost.w));             // RULE4
  end

  assign req_ready   = state_reg == ST_IDLE;
  assign accept      = req_valid && req_ready;
  assign has_cycles  = reads_left_reg != 3'h0 || writes_left_reg != 2'h0;
  assign plan_cycles = plan_r_reg != 3'h0 || plan_w_reg != 2'h0;
  assign issue       = state_reg == ST_BUS && !eng_active && has_cycles;
  assign finish      = (state_reg == ST_INTERNAL && idle_left_reg == 6'h01 && !plan_cycles) ||
                       (state_reg == ST_BUS && eng_done && !has_cycles);
  assign bus_wait    = eng_wait;
  assign done        = done_reg;
  assign err         = err_reg;
  assign total_clks  = total_reg;
  assign wait_clks   = wait_out_reg;
  assign read_cycles = plan_r_reg;
  assign write_cycles = plan_w_reg;

  itc_bus_cycle u_bus (
    .clock      (clock),
    .rst_b      (rst_b),
    .start      (issue),
    .write_in   (reads_left_reg == 3'h0),
    .ready_sync (ready_sync_reg),
    .bus_active (bus_active),
    .bus_write  (bus_write),
    .cyc_done   (eng_done),
    .wait_clk   (eng_wait)
  );

  // mirrors the bus engine's busy flag; avoids a loop through its start input
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cyc_busy_reg <= 1'b0;
    end else if (issue) begin
      cyc_busy_reg <= 1'b1;
    end else if (eng_done) begin
      cyc_busy_reg <= 1'b0;
    end
  end

  assign eng_active = cyc_busy_reg;

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      ready_meta_reg <= 1'b0;
      ready_sync_reg <= 1'b0;
    end else begin
      ready_meta_reg <= mem_ready;
      ready_sync_reg <= ready_meta_reg;
    end
  end

  // plan capture
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      plan_n_reg    <= 6'h00;
      plan_r_reg    <= 3'h0;
      plan_w_reg    <= 2'h0;
      plan_idle_reg <= 6'h00;
    end else if (accept) begin
      plan_n_reg    <= cost.ok ? cost.n : 6'h00;                             // RULE3
      plan_r_reg    <= cost.ok ? cost.r : 3'h0;
      plan_w_reg    <= cost.ok ? cost.w : 2'h0;
      plan_idle_reg <= cost.ok ? idle_calc : 6'h00;
    end
  end

  // sequencing: internal idle clocks first, then reads, then writes
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state_reg       <= ST_IDLE;
      idle_left_reg   <= 6'h00;
      reads_left_reg  <= 3'h0;
      writes_left_reg <= 2'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (accept && cost.ok) begin
            idle_left_reg   <= idle_calc;
            reads_left_reg  <= cost.r;
            writes_left_reg <= cost.w;
            if (idle_calc != 6'h00) begin
              state_reg <= ST_INTERNAL;
            end else if (cost.r != 3'h0 || cost.w != 2'h0) begin
              state_reg <= ST_BUS;
            end
          end
        end
        ST_INTERNAL: begin
          idle_left_reg <= idle_left_reg - 6'h01;                            // RULE4
          if (idle_left_reg == 6'h01) begin
            state_reg <= plan_cycles ? ST_BUS : ST_IDLE;
          end
        end
        ST_BUS: begin
          if (issue && reads_left_reg != 3'h0) begin
            reads_left_reg <= reads_left_reg - 3'h1;
          end else if (issue) begin
            writes_left_reg <= writes_left_reg - 2'h1;
          end
          if (finish) begin
            state_reg <= ST_IDLE;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // elapsed and wait accounting
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      elapsed_reg <= 16'h0000;
      waits_reg   <= 16'h0000;
    end else if (accept) begin
      elapsed_reg <= 16'h0000;
      waits_reg   <= 16'h0000;
    end else if (state_reg != ST_IDLE) begin
      elapsed_reg <= elapsed_reg + 16'h0001;                                 // RULE2
      waits_reg   <= waits_reg + {15'h0000, eng_wait};
    end
  end

  // report
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      done_reg     <= 1'b0;
      err_reg      <= 1'b0;
      total_reg    <= 16'h0000;
      wait_out_reg <= 16'h0000;
    end else begin
      done_reg <= finish || (accept && (!cost.ok || cost.n == 6'h00));
      err_reg  <= accept && !cost.ok;
      if (finish) begin
        total_reg    <= elapsed_reg + 16'h0001;                              // RULE17
        wait_out_reg <= waits_reg;
      end else if (accept) begin
        total_reg    <= 16'h0000;
        wait_out_reg <= 16'h0000;
      end
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  sequence s_accept_ea(itc_mode_t m, logic l, logic f);
    accept && req_op == ITC_OP_EA_CALC && req_src_mode == m && req_long == l && req_fetch == f;
  endsequence

  chk_total_balance: assert property (done_reg && !err_reg |-> total_reg == // RULE17
    {10'h000, plan_n_reg} + wait_out_reg)
    else $error("reported total differs from table plus wait clocks");
  chk_idle_balance: assert property (done_reg && !err_reg |-> plan_n_reg == // RULE4
    plan_idle_reg + 6'(BUS_CYCLE_CLKS * (plan_r_reg + plan_w_reg)))
    else $error("idle clocks do not balance the bus cycles");
  chk_ea_no_write: assert property (accept && req_op == ITC_OP_EA_CALC |=> plan_w_reg == 2'h0) // RULE6
    else $error("address calculation planned a write");
  chk_reg_direct_zero: assert property (s_accept_ea(ITC_EA_AREG, 1'b1, 1'b1) |=> // RULE7
    plan_n_reg == 6'h00 && plan_r_reg == 3'h0 && done_reg)
    else $error("register direct not zero cost");
  chk_postinc_cost: assert property (s_accept_ea(ITC_EA_POSTINC, 1'b1, 1'b1) |=> // RULE8
    plan_n_reg == 6'h08 && plan_r_reg == 3'h2)
    else $error("postincrement long fetch cost wrong");
  chk_predec_cost: assert property (s_accept_ea(ITC_EA_PREDEC, 1'b0, 1'b1) |=> // RULE9
    plan_n_reg == 6'h06 && plan_r_reg == 3'h1)
    else $error("predecrement cost wrong");
  chk_index_cost: assert property (s_accept_ea(ITC_EA_INDEX, 1'b0, 1'b0) |=> // RULE10
    plan_n_reg == 6'h08 && plan_r_reg == 3'h1)
    else $error("indexed no fetch cost wrong");
  chk_abs_long_cost: assert property (s_accept_ea(ITC_EA_ABS_L, 1'b1, 1'b1) |=> // RULE11
    plan_n_reg == 6'h10 && plan_r_reg == 3'h4)
    else $error("absolute long cost wrong");
  chk_imm_cost: assert property (s_accept_ea(ITC_EA_IMM, 1'b0, 1'b1) |=> // RULE12
    plan_n_reg == 6'h04 && plan_r_reg == 3'h1)
    else $error("immediate cost wrong");
  chk_move_cost: assert property (accept && req_op == ITC_OP_MOVE_BW && !req_long && // RULE15
    req_src_mode == ITC_EA_DREG && req_dst_mode == ITC_EA_ABS_L |=>
    plan_n_reg == 6'h10 && plan_r_reg == 3'h3 && plan_w_reg == 2'h1)
    else $error("register to absolute long move cost wrong");
  chk_loop_cont: assert property (accept && req_op == ITC_OP_LOOP_CONT && cost.ok |=> // RULE16
    plan_n_reg == 6'h0A && plan_r_reg == 3'h0 && plan_w_reg == 2'h1)
    else $error("loop continue cost wrong");
  chk_write_after_reads: assert property (issue && bus_write |-> reads_left_reg == 3'h0) // RULE5
    else $error("write issued before all reads");
endmodule

// >>> shared/itc_pkg.sv
// constants, encodings and cost tables for the instruction cycle timing block
// assumes a single processor clock; all figures are counted in its periods
// Summary of operation
// RULE1: every read or write bus cycle lasts four clocks when memory answers at once.
// RULE2: slow memory stretches the bus cycle; each wait clock adds to the total.
// RULE3: each operation reports total clocks, read cycles and write cycles.
// RULE4: clocks not spent in bus cycles are idle clocks for internal work.
// RULE5: an instruction total includes its own fetch and all operand fetches and stores.
// RULE6: address calculation fetches extensions and operands but never writes.
// RULE7: data and address register direct cost zero clocks and zero cycles.
// RULE8: indirect and postincrement cost 4(1/0) or 8(2/0); without fetch 2 and 4.
// RULE9: predecrement 6(1/0) or 10(2/0); displacement 8(2/0) or 12(3/0); no fetch 4.
// RULE10: indexed 10(2/0) or 14(3/0), no fetch 8(1/0); absolute short 8, 12, 4(1/0).
// RULE11: absolute long 12(3/0), 16(4/0), no fetch 8(2/0); pc displacement 8 or 12.
// RULE12: pc indexed 10(2/0) or 14(3/0); immediate 4(1/0) or 8(2/0).
// RULE13: index register size never changes the time of any indexed mode.
// RULE14: move totals include instruction fetch, source reads and destination writes.
// RULE15: register moves cost 4, 8, 12, 14 or 16 clocks by destination mode.
// RULE16: loop move continues in 10(0/1); terminates in 18 or 16 with two reads.
// RULE17: each reported total is the table figure plus all inserted wait clocks.
package itc_pkg;

  localparam int unsigned BUS_CYCLE_CLKS   = 4;
  localparam logic [5:0] MOVE_BASE_CLKS    = 6'h04;
  localparam logic [5:0] LOOP_CONT_CLKS    = 6'h0A;
  localparam logic [5:0] LOOP_TERM_CC_CLKS = 6'h12;
  localparam logic [5:0] LOOP_TERM_EX_CLKS = 6'h10;
  localparam logic [2:0] LOOP_TERM_READS   = 3'h2;

  typedef enum logic [3:0] {
    ITC_EA_DREG, ITC_EA_AREG, ITC_EA_IND, ITC_EA_POSTINC, ITC_EA_PREDEC, ITC_EA_DISP,
    ITC_EA_INDEX, ITC_EA_ABS_W, ITC_EA_ABS_L, ITC_EA_PC_DISP, ITC_EA_PC_INDEX, ITC_EA_IMM
  } itc_mode_t;

  typedef enum logic [2:0] {
    ITC_OP_EA_CALC, ITC_OP_MOVE_BW, ITC_OP_LOOP_CONT, ITC_OP_LOOP_TERM_CC,
    ITC_OP_LOOP_TERM_EX
  } itc_op_t;

  typedef struct packed {
    logic       ok;
    logic [5:0] n;
    logic [2:0] r;
    logic [1:0] w;
  } itc_cost_t;

  // byte/word fetch cost; with fetch, long adds one read of 4 clocks for memory modes
  function automatic itc_cost_t itc_ea_cost(input itc_mode_t m, input logic lng,
                                            input logic fetch);
    itc_cost_t c;
    c = '{ok: 1'b1, n: 6'h00, r: 3'h0, w: 2'h0};
    if (fetch) begin
      case (m)
        ITC_EA_DREG, ITC_EA_AREG: c.n = 6'h00; // RULE7
        ITC_EA_IND, ITC_EA_POSTINC: begin c.n = 6'h04; c.r = 3'h1; end
        ITC_EA_PREDEC: begin c.n = 6'h06; c.r = 3'h1; end
        ITC_EA_DISP, ITC_EA_ABS_W, ITC_EA_PC_DISP: begin c.n = 6'h08; c.r = 3'h2; end
        ITC_EA_INDEX, ITC_EA_PC_INDEX: begin c.n = 6'h0A; c.r = 3'h2; end
        ITC_EA_ABS_L: begin c.n = 6'h0C; c.r = 3'h3; end
        ITC_EA_IMM: begin c.n = 6'h04; c.r = 3'h1; end
        default: c.ok = 1'b0;
      endcase
      if (lng && m != ITC_EA_DREG && m != ITC_EA_AREG) begin // RULE8 RULE9 RULE10 RULE11 RULE12
        c.n = c.n + 6'h04;
        c.r = c.r + 3'h1;
      end
    end else begin
      case (m)
        ITC_EA_IND: c.n = 6'h02;
        ITC_EA_POSTINC, ITC_EA_PREDEC: c.n = 6'h04;
        ITC_EA_DISP: begin c.n = 6'h04; c.r = {2'h0, lng}; end
        ITC_EA_INDEX: begin c.n = 6'h08; c.r = 3'h1; end
        ITC_EA_ABS_W: begin c.n = 6'h04; c.r = 3'h1; end
        ITC_EA_ABS_L: begin c.n = 6'h08; c.r = 3'h2; end
        default: c.ok = 1'b0;
      endcase
    end
    return c;
  endfunction

  // destination share of a byte/word move
  function automatic itc_cost_t itc_dst_cost(input itc_mode_t m);
    itc_cost_t c;
    c = '{ok: 1'b1, n: 6'h00, r: 3'h0, w: 2'h1};
    case (m)
      ITC_EA_DREG, ITC_EA_AREG: c.w = 2'h0;
      ITC_EA_IND, ITC_EA_POSTINC, ITC_EA_PREDEC: c.n = 6'h04;
      ITC_EA_DISP, ITC_EA_ABS_W: begin c.n = 6'h08; c.r = 3'h1; end
      ITC_EA_INDEX: begin c.n = 6'h0A; c.r = 3'h1; end
      ITC_EA_ABS_L: begin c.n = 6'h0C; c.r = 3'h2; end // RULE15
      default: begin c.ok = 1'b0; c.w = 2'h0; end
    endcase
    return c;
  endfunction

endpackage

// >>> verif/instruction_cycle_timing_tb_top.sv
// self-checking bench for the cycle-count engine
// assumes the memory partner answers every bus cycle the core starts
`timescale 1ns/10ps
module instruction_cycle_timing_tb_top
  import itc_pkg::*;
;
  logic        clock, rst_b, req_valid, req_long, req_fetch, req_ready, mem_ready;
  logic        bus_active, bus_write, bus_wait, done, err;
  itc_op_t     req_op;
  itc_mode_t   req_src_mode, req_dst_mode;
  logic [15:0] total_clks, wait_clks;
  logic [2:0]  read_cycles;
  logic [1:0]  write_cycles;
  logic [3:0]  stall;
  int          error_cnt, tests_run;
  // expected costs per mode, -1 where the combination is refused
  int          fn[12] = '{0, 0, 4, 4, 6, 8, 10, 8, 12, 8, 10, 4};
  int          fr[12] = '{0, 0, 1, 1, 1, 2, 2, 2, 3, 2, 2, 1};
  int          nn[12] = '{-1, -1, 2, 4, 4, 4, 8, 4, 8, -1, -1, -1};
  int          nr[12] = '{0, 0, 0, 0, 0, 0, 1, 1, 2, 0, 0, 0};
  int          dn[12] = '{0, 0, 4, 4, 4, 8, 10, 8, 12, -1, -1, -1};
  int          dr[12] = '{0, 0, 0, 0, 0, 1, 1, 1, 2, 0, 0, 0};

  itc_timing_core dut_u (
    .clock(clock), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
    .req_src_mode(req_src_mode), .req_dst_mode(req_dst_mode), .req_long(req_long),
    .req_fetch(req_fetch), .req_ready(req_ready), .mem_ready(mem_ready),
    .bus_active(bus_active), .bus_write(bus_write), .bus_wait(bus_wait), .done(done),
    .err(err), .total_clks(total_clks), .read_cycles(read_cycles),
    .write_cycles(write_cycles), .wait_clks(wait_clks)
  );

  itc_mem_model mem_u (
    .clock(clock), .bus_active(bus_active), .bus_wait(bus_wait), .stall(stall),
    .mem_ready(mem_ready)
  );

  always #50 clock = ~clock;

  task automatic end_sim();
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %0d seen %0d", nm, exp, got);
    end
  endtask

  // one request: hold until taken, then watch the bus until done
  task automatic run(input itc_op_t op, input int s, input int d, input logic lng,
                     input logic f, input int en, input int er, input int ew,
                     input logic [3:0] stl);
    int k;
    int act;
    int wr;
    int wt;
    act = 0;
    wr = 0;
    wt = 0;
    stall = stl;
    @(posedge clock);
    req_valid <= 1'b1;
    req_op <= op;
    req_src_mode <= itc_mode_t'(s);
    req_dst_mode <= itc_mode_t'(d);
    req_long <= lng;
    req_fetch <= f;
    for (k = 0; k < 50; k++) begin
      @(negedge clock);
      if (req_ready === 1'b1) break;
    end
    if (k >= 50) begin
      chk("ready_timeout", 1, 0);
      end_sim();
    end
    @(posedge clock);
    req_valid <= 1'b0;
    for (k = 1; k <= 300; k++) begin
      @(negedge clock);
      act += int'(bus_active === 1'b1);
      wr += int'(bus_active === 1'b1 && bus_write === 1'b1);
      wt += int'(bus_wait === 1'b1);
      if (done === 1'b1) break;
    end
    if (k > 300) begin
      chk("done_timeout", 1, 0);
      end_sim();
    end
    chk("err", en < 0, err);
    if (en < 0) begin
      en = 0;
      er = 0;
      ew = 0;
    end
    chk("bus_waits", int'(stl) * (er + ew), wt);
    chk("latency", en + wt + 1, k);
    chk("total_clks", en + wt, total_clks);
    chk("wait_clks", wt, wait_clks);
    chk("read_cycles", er, read_cycles);
    chk("write_cycles", ew, write_cycles);
    chk("bus_clks", 4 * (er + ew) + wt, act);
    if (wt == 0) chk("write_clks", 4 * ew, wr);
  endtask

  task automatic test_ea();
    int n;
    int r;
    for (int m = 0; m < 12; m++) begin
      for (int l = 0; l < 2; l++) begin
        n = fn[m] + ((m > 1 && l == 1) ? 4 : 0);
        r = fr[m] + ((m > 1 && l == 1) ? 1 : 0);
        run(ITC_OP_EA_CALC, m, 0, l[0], 1'b1, n, r, 0, 4'h0);
        r = nr[m] + ((m == 5 && l == 1) ? 1 : 0);
        run(ITC_OP_EA_CALC, m, 0, l[0], 1'b0, nn[m], r, 0, 4'h0);
      end
    end
  endtask

  task automatic test_move();
    for (int s = 0; s < 12; s++) begin
      for (int d = 0; d < 12; d++) begin
        if (dn[d] < 0) begin
          run(ITC_OP_MOVE_BW, s, d, 1'b0, 1'b1, -1, 0, 0, 4'h0);
        end else begin
          run(ITC_OP_MOVE_BW, s, d, 1'b0, 1'b1, 4 + fn[s] + dn[d],
              1 + fr[s] + dr[d], int'(d > 1), 4'h0);
        end
      end
    end
    run(ITC_OP_MOVE_BW, 0, 2, 1'b1, 1'b1, -1, 0, 0, 4'h0);
  endtask

  task automatic test_loop();
    run(ITC_OP_LOOP_CONT, 0, 2, 1'b0, 1'b1, 10, 0, 1, 4'h0);
    run(ITC_OP_LOOP_TERM_CC, 1, 3, 1'b0, 1'b1, 18, 2, 1, 4'h0);
    run(ITC_OP_LOOP_TERM_EX, 0, 3, 1'b0, 1'b1, 16, 2, 1, 4'h0);
    run(ITC_OP_LOOP_CONT, 0, 4, 1'b0, 1'b1, -1, 0, 0, 4'h0);
  endtask

  task automatic test_wait();
    run(ITC_OP_EA_CALC, 2, 0, 1'b0, 1'b1, 4, 1, 0, 4'h3);
    chk("waits_seen", 1, wait_clks != 16'h0000);
    run(ITC_OP_MOVE_BW, 8, 8, 1'b0, 1'b1, 28, 6, 1, 4'h2);
    chk("waits_seen", 1, wait_clks != 16'h0000);
    run(ITC_OP_EA_CALC, 4, 0, 1'b1, 1'b1, 10, 2, 0, 4'h0);
  endtask

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    req_valid = 1'b0;
    req_op = ITC_OP_EA_CALC;
    req_src_mode = ITC_EA_DREG;
    req_dst_mode = ITC_EA_DREG;
    req_long = 1'b0;
    req_fetch = 1'b0;
    stall = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    chk("req_ready", 1, req_ready);
    chk("total_clks", 0, total_clks);
    test_ea();
    test_move();
    test_loop();
    test_wait();
    end_sim();
  end
endmodule

// >>> verif/itc_mem_model.sv
// memory partner: answers each bus cycle at once or late
// assumes bus_active is high on every clock of a bus cycle and bus_wait on each wait clock
`timescale 1ns/10ps
module itc_mem_model (
  input  wire logic       clock,
  input  wire logic       bus_active,
  input  wire logic       bus_wait,
  input  wire logic [3:0] stall,
  output logic            mem_ready
);
  logic [1:0] ph_reg;
  logic [3:0] left_reg;
  logic       first;

  initial begin
    ph_reg = 2'h0;
    left_reg = 4'h0;
  end

  // phase of the coming clock; back-to-back cycles restart after the last clock
  assign first = bus_active && ph_reg == 2'h0;

  // slow memory holds ready low from the first clock of every cycle
  always @(posedge clock) begin
    if (!bus_active || (ph_reg == 2'h3 && !bus_wait)) begin
      ph_reg <= 2'h0;
    end else if (ph_reg != 2'h3) begin
      ph_reg <= ph_reg + 2'h1;
    end
    if (first && stall != 4'h0) begin
      left_reg <= stall;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end

  assign mem_ready = !(left_reg != 4'h0 || (first && stall != 4'h0));
endmodule
